// ==== rtl/mts_map.svh ====
// register offsets, field positions, reset values and counts of the timer
// suite; assumes an 8-bit register port with 16-bit addresses.
// How it works
// R01: four timers, counts as two bytes
// R02: core timers tick at clock over twelve
// R03: core overflow irq only when enabled
// R04: mode 0 uses high byte, low 5
// R05: 13-bit all ones wraps, sets flag
// R06: modes 0-2 gated only by run bit, except timer 1 while timer 0 is split
// R07: mode 1 wraps FFFF to zero, flags
// R08: mode 2 reloads low from high byte
// R09: split low byte uses timer 0 controls
// R10: split high byte uses timer 1 controls
// R11: split: timer 1 runs unless mode 3
// R12: split: timer 1 raises no overflow
// R13: rtc timer identical to general timer
// R14: source select; divider on fast sources only
// R15: count up, interrupt at compare
// R16: interval is clock times compare plus one
// R17: single shot clears enable, stops
// R18: auto reload keeps enable, restarts
// R19: software stops by clearing enable
// R20: compare or config write clears counter
// R21: gp irqs wake device; software clears
// R22: mode field encoding 00 to 11
// R23: hardware sets overflow; software writable
// R24: overflow flag sticky until software clears
// R25: new compare and mode apply next interval
`ifndef MTS_MAP_SVH
`define MTS_MAP_SVH

`define MTS_ADDR_CORE_TIMER_CONTROL_REG     16'h0088
`define MTS_ADDR_CORE_TIMER_MODE_REG     16'h0089
`define MTS_ADDR_C0LOW    16'h008A
`define MTS_ADDR_C1LOW    16'h008B
`define MTS_ADDR_C0HIGH   16'h008C
`define MTS_ADDR_C1HIGH   16'h008D
`define MTS_ADDR_IEN      16'h00A8
`define MTS_ADDR_GP_LOW   16'h2068
`define MTS_ADDR_GP_HIGH  16'h2069
`define MTS_ADDR_GP_CFG   16'h206A
`define MTS_ADDR_RTC_LOW  16'h206B
`define MTS_ADDR_RTC_HIGH 16'h206C
`define MTS_ADDR_RTC_CFG  16'h206D
`define MTS_ADDR_GP_STAT  16'h206E

`define MTS_CORE_TIMER_CONTROL_REG_TF1   7
`define MTS_CORE_TIMER_CONTROL_REG_TR1   6
`define MTS_CORE_TIMER_CONTROL_REG_TF0   5
`define MTS_CORE_TIMER_CONTROL_REG_TR0   4
`define MTS_CORE_TIMER_MODE_REG_T1    6
`define MTS_CORE_TIMER_MODE_REG_M1_LO 4
`define MTS_CORE_TIMER_MODE_REG_T0    2
`define MTS_CORE_TIMER_MODE_REG_M0_LO 0
`define MTS_IEN_ET1    3
`define MTS_IEN_ET0    1
`define MTS_STAT_GP    0
`define MTS_STAT_RTC   1

`define MTS_CFG_EN     0
`define MTS_CFG_RLD    1
`define MTS_CFG_SEL_LO 2
`define MTS_CFG_FRE_LO 4

`define MTS_RESET_BYTE 8'h00
`define MTS_CORE_DIV   4'hC

`endif

// ==== rtl/mts_pkg.sv ====
// types shared by the timer suite; field positions live in mts_map.svh.
package mts_pkg;

    // 2-bit mode field: 13-bit, 16-bit, 8-bit reload, split/stopped
    typedef enum logic [1:0] {
        MTS_M13,
        MTS_M16,
        MTS_M8R,
        MTS_MSPLIT
    } mts_core_mode_t;

    typedef enum logic [1:0] {
        MTS_SRC_SLOW,
        MTS_SRC_EXT,
        MTS_SRC_PLL,
        MTS_SRC_OFF
    } mts_src_sel_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } mts_bus_req_t;

    // one-cycle enables, one per source clock edge, already synchronous
    typedef struct packed {
        logic slowTick;
        logic extTick;
        logic pllTick;
    } mts_src_t;

endpackage

// ==== rtl/mts_gp_timer.sv ====
// one compare timer (general or rtc): config, compare bytes, counter.
// assumes source ticks are one-cycle enables on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "mts_map.svh"
module mts_gp_timer (
    input  wire logic              ref_clk,  // system clock
    input  wire logic              reset_n,  // sync reset, active low
    input  wire mts_pkg::mts_src_t srcTick,  // source clock enables
    input  wire logic              wrCfg,    // config write strobe
    input  wire logic              wrLow,    // compare low write strobe
    input  wire logic              wrHigh,   // compare high write strobe
    input  wire logic [7:0]        wrData,   // write data
    output logic      [7:0]        cfg,      // config register
    output logic      [7:0]        cmpLow,   // compare low byte
    output logic      [7:0]        cmpHigh,  // compare high byte
    output logic                   hit       // compare reached pulse
);
    import mts_pkg::*;

    logic [15:0]  count;
    logic [6:0]   pre;
    logic [7:0]   divPow;
    logic [6:0]   divMask;
    logic         rawTick;
    logic         divTick;
    logic         wrAny;
    logic         hitNow;
    mts_src_sel_t srcSel;

    assign wrAny   = wrCfg | wrLow | wrHigh;
    assign srcSel  = mts_src_sel_t'(cfg[`MTS_CFG_SEL_LO +: 2]);
    assign divPow  = 8'h01 << cfg[`MTS_CFG_FRE_LO +: 3];
    assign divMask = 7'(divPow - 8'h01);

    always_comb begin
        case (srcSel) // R14
            MTS_SRC_SLOW: rawTick = srcTick.slowTick;
            MTS_SRC_EXT:  rawTick = srcTick.extTick;
            MTS_SRC_PLL:  rawTick = srcTick.pllTick;
            default:      rawTick = 1'b0;
        endcase
    end

    // slow oscillator bypasses the divider
    assign divTick = rawTick & ((srcSel == MTS_SRC_SLOW) || (pre == divMask));
    assign hitNow  = cfg[`MTS_CFG_EN] & divTick & (count == {cmpHigh, cmpLow})
                     & ~wrAny; // R15

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pre <= 7'h00;
        end else if (wrAny || (rawTick && pre == divMask)) begin
            pre <= 7'h00;
        end else if (rawTick) begin
            pre <= pre + 7'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            count <= 16'h0000;
        end else if (wrAny) begin
            count <= 16'h0000; // R20 R25
        end else if (hitNow) begin
            count <= 16'h0000; // R16 R18
        end else if (cfg[`MTS_CFG_EN] && divTick) begin
            count <= count + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cfg <= `MTS_RESET_BYTE;
        end else if (wrCfg) begin
            cfg <= wrData; // R19
        end else if (hitNow && !cfg[`MTS_CFG_RLD]) begin
            cfg[`MTS_CFG_EN] <= 1'b0; // R17
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cmpLow  <= `MTS_RESET_BYTE;
            cmpHigh <= `MTS_RESET_BYTE;
        end else begin
            if (wrLow)
                cmpLow <= wrData;
            if (wrHigh)
                cmpHigh <= wrData;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n)
            hit <= 1'b0;
        else
            hit <= hitNow;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_write_clears: assert property (wrAny |=> count == 16'h0000) // R20
        else $error("counter not cleared by config write");
    a_oneshot_stop: assert property (hitNow && !cfg[`MTS_CFG_RLD] && !wrCfg
        |=> !cfg[`MTS_CFG_EN] ##1 $stable(count)) // R17
        else $error("single shot did not stop");
    a_reload_runs: assert property (hitNow && cfg[`MTS_CFG_RLD] && !wrCfg
        |=> cfg[`MTS_CFG_EN] && hit && count == 16'h0000) // R18
        else $error("auto reload did not restart");
    c_reload_hit: cover property (hit && cfg[`MTS_CFG_RLD]);

endmodule
`default_nettype wire

// ==== rtl/mts_timer_suite.sv ====
// top of the timer suite: two core timers, general and rtc timers,
// register port. assumes bus strobes are one cycle and never overlap.
`timescale 1ns/1ps
`default_nettype none
`include "mts_map.svh"
module mts_timer_suite (
    input  wire logic                  ref_clk,  // 20 MHz system clock
    input  wire logic                  reset_n,  // sync reset, active low
    input  wire mts_pkg::mts_bus_req_t busReq,   // register request
    input  wire mts_pkg::mts_src_t     srcTick,  // gp source enables
    output logic [7:0]                 rdData,   // read data, next cycle
    output logic                       core0Irq, // timer 0 request
    output logic                       core1Irq, // timer 1 request
    output logic                       gpIrq,    // general timer request
    output logic                       rtcIrq,   // rtc timer request
    output logic                       wakeReq   // wake from wait/sleep
);
    import mts_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // register state

    logic [3:0]     divCnt;
    logic           tick12;
    logic [7:0]     c0Low;
    logic [7:0]     c0High;
    logic [7:0]     c1Low;
    logic [7:0]     c1High;
    logic           tf0;
    logic           tf1;
    logic           tr0;
    logic           tr1;
    logic           t0Sel;
    logic           t1Sel;
    mts_core_mode_t m0;
    mts_core_mode_t m1;
    logic           et0;
    logic           et1;
    logic           gpFlag;
    logic           rtcFlag;

    logic [7:0]     gpCfg;
    logic [7:0]     gpCmpLow;
    logic [7:0]     gpCmpHigh;
    logic           gpHit;
    logic [7:0]     rtcCfg;
    logic [7:0]     rtcCmpLow;
    logic [7:0]     rtcCmpHigh;
    logic           rtcHit;

    logic           wrTcon;
    logic           wrStat;
    logic           split0;
    logic           run0;
    logic           run1;
    logic           runHigh;
    logic [16:0]    step0;
    logic [16:0]    step1;
    logic [7:0]     next_c0Low;
    logic [7:0]     next_c0High;
    logic [7:0]     next_c1Low;
    logic [7:0]     next_c1High;
    logic           ovf0;
    logic           ovf1;
    logic           ovfHigh;

    assign wrTcon = busReq.wr && busReq.addr == `MTS_ADDR_CORE_TIMER_CONTROL_REG;
    assign wrStat = busReq.wr && busReq.addr == `MTS_ADDR_GP_STAT;

    ////////////////////////////////////////////////////////////////////
    // system clock over twelve

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            divCnt <= 4'h0;
            tick12 <= 1'b0;
        end else begin
            divCnt <= (divCnt == `MTS_CORE_DIV - 4'h1) ? 4'h0 : divCnt + 4'h1;
            tick12 <= (divCnt == `MTS_CORE_DIV - 4'h1); // R02
        end
    end

    ////////////////////////////////////////////////////////////////////
    // core counting: {overflow, high, low} after one tick

    function automatic logic [16:0] coreStep(input mts_core_mode_t mode,
                                             input logic [15:0] cnt);
        logic [13:0] v13;
        logic [16:0] res;
        v13 = {1'b0, cnt[15:8], cnt[4:0]} + 14'h0001;
        case (mode) // R22
            MTS_M13: res = {v13[13], v13[12:5], cnt[7:5], v13[4:0]}; // R04 R05
            MTS_M16: res = {1'b0, cnt} + 17'h00001; // R07
            MTS_M8R: begin
                if (cnt[7:0] == 8'hFF)
                    res = {1'b1, cnt[15:8], cnt[15:8]}; // R08
                else
                    res = {1'b0, cnt[15:8], cnt[7:0] + 8'h01};
            end
            default: res = {1'b0, cnt};
        endcase
        return res;
    endfunction

    assign split0  = (m0 == MTS_MSPLIT);
    assign run0    = tick12 & tr0; // R06 R09
    assign runHigh = tick12 & tr1 & split0; // R10
    // timer 1 loses its run bit to timer 0 while split; mode alone gates it
    assign run1    = tick12 & (split0 | tr1) & (m1 != MTS_MSPLIT); // R11
    assign step0   = coreStep(m0, {c0High, c0Low});
    assign step1   = coreStep(m1, {c1High, c1Low});

    always_comb begin
        next_c0Low  = c0Low;
        next_c0High = c0High;
        ovf0        = 1'b0;
        ovfHigh     = 1'b0;
        if (split0) begin
            if (run0) begin
                next_c0Low = c0Low + 8'h01; // R09
                ovf0       = (c0Low == 8'hFF);
            end
            if (runHigh) begin
                next_c0High = c0High + 8'h01; // R10
                ovfHigh     = (c0High == 8'hFF);
            end
        end else if (run0) begin
            {ovf0, next_c0High, next_c0Low} = step0;
        end
    end

    always_comb begin
        next_c1Low  = c1Low;
        next_c1High = c1High;
        ovf1        = 1'b0;
        if (run1) begin
            {next_c1High, next_c1Low} = step1[15:0];
            ovf1 = step1[16] & ~split0; // R12
        end
    end

    // a software write to a count byte wins over the tick in that cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            c0Low  <= `MTS_RESET_BYTE;
            c0High <= `MTS_RESET_BYTE;
            c1Low  <= `MTS_RESET_BYTE;
            c1High <= `MTS_RESET_BYTE;
        end else begin
            c0Low  <= (busReq.wr && busReq.addr == `MTS_ADDR_C0LOW)
                      ? busReq.wdata : next_c0Low; // R01
            c0High <= (busReq.wr && busReq.addr == `MTS_ADDR_C0HIGH)
                      ? busReq.wdata : next_c0High;
            c1Low  <= (busReq.wr && busReq.addr == `MTS_ADDR_C1LOW)
                      ? busReq.wdata : next_c1Low;
            c1High <= (busReq.wr && busReq.addr == `MTS_ADDR_C1HIGH)
                      ? busReq.wdata : next_c1High;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control, mode and enable registers

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            tr0 <= 1'b0;
            tr1 <= 1'b0;
        end else if (wrTcon) begin
            tr0 <= busReq.wdata[`MTS_CORE_TIMER_CONTROL_REG_TR0];
            tr1 <= busReq.wdata[`MTS_CORE_TIMER_CONTROL_REG_TR1];
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            tf0 <= 1'b0;
            tf1 <= 1'b0;
        end else begin
            tf0 <= ovf0 | (wrTcon ? busReq.wdata[`MTS_CORE_TIMER_CONTROL_REG_TF0] : tf0); // R23 R24
            tf1 <= ovf1 | ovfHigh
                   | (wrTcon ? busReq.wdata[`MTS_CORE_TIMER_CONTROL_REG_TF1] : tf1); // R10 R23
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            m0    <= MTS_M13;
            m1    <= MTS_M13;
            t0Sel <= 1'b0;
            t1Sel <= 1'b0;
        end else if (busReq.wr && busReq.addr == `MTS_ADDR_CORE_TIMER_MODE_REG) begin
            m0    <= mts_core_mode_t'(busReq.wdata[`MTS_CORE_TIMER_MODE_REG_M0_LO +: 2]);
            m1    <= mts_core_mode_t'(busReq.wdata[`MTS_CORE_TIMER_MODE_REG_M1_LO +: 2]);
            t0Sel <= busReq.wdata[`MTS_CORE_TIMER_MODE_REG_T0];
            t1Sel <= busReq.wdata[`MTS_CORE_TIMER_MODE_REG_T1];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            et0 <= 1'b0;
            et1 <= 1'b0;
        end else if (busReq.wr && busReq.addr == `MTS_ADDR_IEN) begin
            et0 <= busReq.wdata[`MTS_IEN_ET0];
            et1 <= busReq.wdata[`MTS_IEN_ET1];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // general and rtc timers

    mts_gp_timer u_gp (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .srcTick (srcTick),
        .wrCfg   (busReq.wr && busReq.addr == `MTS_ADDR_GP_CFG),
        .wrLow   (busReq.wr && busReq.addr == `MTS_ADDR_GP_LOW),
        .wrHigh  (busReq.wr && busReq.addr == `MTS_ADDR_GP_HIGH),
        .wrData  (busReq.wdata),
        .cfg     (gpCfg),
        .cmpLow  (gpCmpLow),
        .cmpHigh (gpCmpHigh),
        .hit     (gpHit)
    );

    // same logic, own registers
    mts_gp_timer u_rtc ( // R13
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .srcTick (srcTick),
        .wrCfg   (busReq.wr && busReq.addr == `MTS_ADDR_RTC_CFG),
        .wrLow   (busReq.wr && busReq.addr == `MTS_ADDR_RTC_LOW),
        .wrHigh  (busReq.wr && busReq.addr == `MTS_ADDR_RTC_HIGH),
        .wrData  (busReq.wdata),
        .cfg     (rtcCfg),
        .cmpLow  (rtcCmpLow),
        .cmpHigh (rtcCmpHigh),
        .hit     (rtcHit)
    );

    // write one to clear; a hit in the clearing cycle keeps the flag
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            gpFlag  <= 1'b0;
            rtcFlag <= 1'b0;
        end else begin
            gpFlag  <= gpHit | (gpFlag
                       & ~(wrStat & busReq.wdata[`MTS_STAT_GP])); // R21
            rtcFlag <= rtcHit | (rtcFlag
                       & ~(wrStat & busReq.wdata[`MTS_STAT_RTC]));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // requests and read port

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            core0Irq <= 1'b0;
            core1Irq <= 1'b0;
            gpIrq    <= 1'b0;
            rtcIrq   <= 1'b0;
            wakeReq  <= 1'b0;
        end else begin
            core0Irq <= tf0 & et0; // R03
            core1Irq <= tf1 & et1;
            gpIrq    <= gpFlag;
            rtcIrq   <= rtcFlag;
            wakeReq  <= gpFlag | rtcFlag; // R21
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rdData <= 8'h00;
        end else if (!busReq.rd) begin
            rdData <= 8'h00;
        end else begin
            case (busReq.addr)
                `MTS_ADDR_CORE_TIMER_CONTROL_REG:     rdData <= {tf1, tr1, tf0, tr0, 4'h0};
                `MTS_ADDR_CORE_TIMER_MODE_REG:     rdData <= {1'b0, t1Sel, m1, 1'b0, t0Sel, m0};
                `MTS_ADDR_C0LOW:    rdData <= c0Low; // R01
                `MTS_ADDR_C0HIGH:   rdData <= c0High;
                `MTS_ADDR_C1LOW:    rdData <= c1Low;
                `MTS_ADDR_C1HIGH:   rdData <= c1High;
                `MTS_ADDR_IEN:      rdData <= {4'h0, et1, 1'b0, et0, 1'b0};
                `MTS_ADDR_GP_LOW:   rdData <= gpCmpLow;
                `MTS_ADDR_GP_HIGH:  rdData <= gpCmpHigh;
                `MTS_ADDR_GP_CFG:   rdData <= gpCfg;
                `MTS_ADDR_RTC_LOW:  rdData <= rtcCmpLow;
                `MTS_ADDR_RTC_HIGH: rdData <= rtcCmpHigh;
                `MTS_ADDR_RTC_CFG:  rdData <= rtcCfg;
                `MTS_ADDR_GP_STAT:  rdData <= {6'h00, rtcFlag, gpFlag};
                default:            rdData <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_tick_period: assert property (tick12 |=> !tick12 [*8] ##1 !tick12 [*3]
        ##1 tick12) // R02
        else $error("core tick not every twelve cycles");
    a_irq_gating: assert property (!et0 ##1 1'b1 |-> !core0Irq) // R03
        else $error("timer 0 request while disabled");
    a_irq_raise: assert property (tf0 && et0 |=> core0Irq) // R03
        else $error("timer 0 request missing");
    a_mode13_wrap: assert property (m0 == MTS_M13 && run0 && !busReq.wr
        && c0High == 8'hFF && c0Low[4:0] == 5'h1F
        |=> c0High == 8'h00 && c0Low[4:0] == 5'h00 && tf0
        && c0Low[7:5] == $past(c0Low[7:5])) // R05
        else $error("13-bit wrap wrong");
    a_mode16_wrap: assert property (m0 == MTS_M16 && run0 && !busReq.wr
        && {c0High, c0Low} == 16'hFFFF
        |=> {c0High, c0Low} == 16'h0000 && tf0) // R07
        else $error("16-bit wrap wrong");
    a_reload_load: assert property (m0 == MTS_M8R && run0 && !busReq.wr
        && c0Low == 8'hFF |=> c0Low == $past(c0High) && tf0) // R08
        else $error("8-bit reload wrong");
    a_stop_hold: assert property (m0 != MTS_MSPLIT && !tr0 && !busReq.wr
        |=> $stable({c0High, c0Low})) // R06
        else $error("timer 0 moved while stopped");
    a_t1_mode3: assert property (m1 == MTS_MSPLIT && !busReq.wr
        |=> $stable({c1High, c1Low})) // R11
        else $error("timer 1 moved in mode 3");
    a_split_noflag: assert property (split0 && !wrTcon && !runHigh
        |=> tf1 == $past(tf1)) // R12
        else $error("timer 1 overflow while split");
    a_flag_sticky: assert property (tf0 && !wrTcon |=> tf0) // R24
        else $error("overflow flag lost");
    a_wake_flag: assert property (gpHit |=> gpFlag ##1 wakeReq) // R21
        else $error("general timer did not request wake");

    c_split_high: cover property (split0 && runHigh && c0High == 8'hFF);
    c_mode2_reload: cover property (m1 == MTS_M8R && run1 && c1Low == 8'hFF);
    c_rtc_hit: cover property (rtcHit);
    c_clear_race: cover property (gpHit && wrStat);

endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench for the timer suite, driven through the register port
// assumes a 20 MHz ref_clk and the register map header of the design
`timescale 1ns/1ps
`default_nettype none
`include "mts_map.svh"
module tb_top;
    import mts_pkg::*;
    logic         ref_clk    = 1'h0;
    logic         reset_n    = 1'h0;
    mts_bus_req_t busReq     = '0;
    mts_src_t     srcTick    = '0;
    logic [7:0]   rdData;
    logic [3:0]   irq;
    logic         wakeReq;
    int           errorCnt   = 0;
    int           checksDone = 0;
    int           cyc        = 0;
    int           c;
    logic [7:0]   d;
    logic [7:0]   a;
    logic [15:0]  regs [8]   = '{`MTS_ADDR_CORE_TIMER_CONTROL_REG, `MTS_ADDR_CORE_TIMER_MODE_REG,
        `MTS_ADDR_C0LOW, `MTS_ADDR_C1HIGH, `MTS_ADDR_IEN, `MTS_ADDR_GP_CFG,
        `MTS_ADDR_RTC_HIGH, 16'h0090};

    always #25 ref_clk = ~ref_clk;

    mts_timer_suite DUT (
        .ref_clk  (ref_clk),  // system clock
        .reset_n  (reset_n),  // sync reset
        .busReq   (busReq),   // register request
        .srcTick  (srcTick),  // source enables
        .rdData   (rdData),   // read data
        .core0Irq (irq[0]),   // timer 0 request
        .core1Irq (irq[1]),   // timer 1 request
        .gpIrq    (irq[2]),   // general timer request
        .rtcIrq   (irq[3]),   // rtc timer request
        .wakeReq  (wakeReq)   // wake request
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic printVerdict;
        $display("checks %0d mismatches %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // a hang must still end in the verdict, not in a silent stall
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 15000) begin
            errorCnt++;
            $display("ERROR run length expected end seen timeout");
            printVerdict();
        end
    end

    task automatic wr(input logic [15:0] ad, input logic [7:0] v);
        @(posedge ref_clk);
        busReq <= {ad, v, 2'h2};
        @(posedge ref_clk);
        busReq.wr <= 1'h0;
    endtask

    task automatic rd(input logic [15:0] ad, output logic [7:0] v);
        @(posedge ref_clk);
        busReq <= {ad, 8'h00, 2'h1};
        @(posedge ref_clk);
        busReq.rd <= 1'h0;
        #1 v = rdData;
    endtask

    task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
        checksDone++;
        if (g !== e) begin
            errorCnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rdchk(input string n, logic [15:0] ad, logic [7:0] e);
        rd(ad, d);
        chk(n, e, d);
    endtask

    // polls control until a flag shows, then clears both run bits; timer 1 keeps running while timer 0 is split
    task automatic poll(input logic [7:0] m);
        c = 0;
        do begin
            rd(`MTS_ADDR_CORE_TIMER_CONTROL_REG, d);
            c++;
        end while ((d & m) == 8'h00 && c < 20);
        chk("overflow flag", m, d & m);
        wr(`MTS_ADDR_CORE_TIMER_CONTROL_REG, m);
    endtask

    task automatic tick(input int s);
        repeat ($urandom_range(1, 4)) @(posedge ref_clk);
        srcTick <= 3'h4 >> s;
        @(posedge ref_clk);
        srcTick <= '0;
        repeat (4) @(posedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int cmp;
        int s;
        logic [15:0] b;
        c = $urandom(32'hA14B);
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'h1;
        foreach (regs[i]) rdchk("reset value", regs[i], 8'h00);
        $display("test reset done");

        wr(`MTS_ADDR_CORE_TIMER_MODE_REG, 8'h01);
        wr(`MTS_ADDR_CORE_TIMER_CONTROL_REG, 8'h10);
        rd(`MTS_ADDR_C0LOW, a);
        repeat (22) @(posedge ref_clk);
        rdchk("tick rate", `MTS_ADDR_C0LOW, a + 8'h02);
        wr(`MTS_ADDR_CORE_TIMER_CONTROL_REG, 8'h00);
        wr(`MTS_ADDR_C0LOW, 8'hFF);
        wr(`MTS_ADDR_C0HIGH, 8'hFF);
        wr(`MTS_ADDR_IEN, 8'h02);
        wr(`MTS_ADDR_CORE_TIMER_CONTROL_REG, 8'h10);
        poll(8'h20);
        rdchk("wrap low", `MTS_ADDR_C0LOW, 8'h00);
        rdchk("wrap high", `MTS_ADDR_C0HIGH, 8'h00);
        chk("core0 irq", 8'h01, {7'h00, irq[0]});
        wr(`MTS_ADDR_CORE_TIMER_CONTROL_REG, 8'h00);
        repeat (2) @(posedge ref_clk);
        chk("core0 irq clear", 8'h00, {7'h00, irq[0]});
        $display("test 16-bit done");

        wr(`MTS_ADDR_IEN, 8'h00);
        wr(`MTS_ADDR_CORE_TIMER_MODE_REG, 8'h00);
        wr(`MTS_ADDR_C0LOW, 8'h1F);
        wr(`MTS_ADDR_C0HIGH, 8'hFF);
        wr(`MTS_ADDR_CORE_TIMER_CONTROL_REG, 8'h10);
        poll(8'h20);
        rdchk("13-bit low", `MTS_ADDR_C0LOW, 8'h00);
        rdchk("13-bit high", `MTS_ADDR_C0HIGH, 8'h00);
        chk("masked irq", 8'h00, {7'h00, irq[0]});
        wr(`MTS_ADDR_IEN, 8'h02);
        repeat (2) @(posedge ref_clk);
        chk("pending irq", 8'h01, {7'h00, irq[0]});
        $display("test 13-bit done");

        wr(`MTS_ADDR_CORE_TIMER_MODE_REG, 8'h02);
        wr(`MTS_ADDR_C0LOW, 8'hFF);
        wr(`MTS_ADDR_C0HIGH, 8'h80);
        wr(`MTS_ADDR_CORE_TIMER_CONTROL_REG, 8'h10);
        poll(8'h20);
        rdchk("reload low", `MTS_ADDR_C0LOW, 8'h80);
        rdchk("reload high", `MTS_ADDR_C0HIGH, 8'h80);
        $display("test reload done");

        wr(`MTS_ADDR_IEN, 8'h08);
        wr(`MTS_ADDR_CORE_TIMER_MODE_REG, 8'h03);
        wr(`MTS_ADDR_C0LOW, 8'h00);
        wr(`MTS_ADDR_C0HIGH, 8'hFF);
        wr(`MTS_ADDR_C1LOW, 8'h00);
        wr(`MTS_ADDR_CORE_TIMER_CONTROL_REG, 8'h40);
        poll(8'h80);
        rdchk("split high", `MTS_ADDR_C0HIGH, 8'h00);
        rdchk("split low", `MTS_ADDR_C0LOW, 8'h00);
        chk("core1 irq", 8'h01, {7'h00, irq[1]});
        rd(`MTS_ADDR_C1LOW, a);
        chk("timer1 runs", 8'h01, {7'h00, a != 8'h00});
        wr(`MTS_ADDR_CORE_TIMER_MODE_REG, 8'h33);
        rd(`MTS_ADDR_C1LOW, a);
        repeat (26) @(posedge ref_clk);
        rdchk("timer1 held", `MTS_ADDR_C1LOW, a);
        wr(`MTS_ADDR_CORE_TIMER_CONTROL_REG, 8'h00);
        $display("test split done");

        // general timer first, then rtc; reload pass then single shot
        for (int t = 0; t < 2; t++) begin
            b = t ? `MTS_ADDR_RTC_LOW : `MTS_ADDR_GP_LOW;
            for (int r = 1; r >= 0; r--) begin
                cmp = $urandom_range(1, 3);
                s = $urandom_range(0, 2);
                wr(b, 8'(cmp));
                wr(b + 16'h0001, 8'h00);
                wr(b + 16'h0002, {4'h0, 2'(s), 1'(r), 1'h1});
                tick(s);
                wr(b, 8'(cmp));
                for (int k = 0; k <= cmp; k++) begin
                    tick(s);
                    chk("gp irq", 8'(k == cmp), {7'h00, irq[2 + t]});
                end
                chk("wake", 8'h01, {7'h00, wakeReq});
                rdchk("gp cfg", b + 16'h0002, {4'h0, 2'(s), 1'(r), 1'(r)});
                wr(`MTS_ADDR_GP_STAT, 8'h01 << t);
                repeat (3) @(posedge ref_clk);
                chk("gp clear", 8'h00, {6'h00, wakeReq, irq[2 + t]});
                wr(b + 16'h0002, {4'h0, 2'(s), 1'(r), 1'h0});
                repeat (cmp + 1) tick(s);
                chk("gp stopped", 8'h00, {7'h00, irq[2 + t]});
            end
            $display("test compare timer %0d done", t);
        end
        printVerdict();
    end
endmodule
`default_nettype wire
